// ==== hdl/pdxmb_defs.svh ====
// constants of the extended message builder: offsets, codes, fields, reset values
`ifndef PDXMB_DEFS_SVH
`define PDXMB_DEFS_SVH

// ===================================================================
// extended message type codes
`define PDXMB_XT_RSVD0 5'h00
`define PDXMB_XT_SRC_CAP_EXT 5'h01
`define PDXMB_XT_SRC_STATUS 5'h02
`define PDXMB_XT_GET_BAT_CAP 5'h03
`define PDXMB_XT_GET_BAT_STAT 5'h04
`define PDXMB_XT_BAT_CAPS 5'h05
`define PDXMB_XT_GET_MFR 5'h06
`define PDXMB_XT_MFR_INFO 5'h07
`define PDXMB_XT_SEC_REQ 5'h08
`define PDXMB_XT_SEC_RESP 5'h09
`define PDXMB_XT_FIRST_RSVD 5'h0a
// non-extended codes used here
`define PDXMB_CT_GET_SRC_CAP_EXT 5'h11
`define PDXMB_DT_SRC_ALERT 5'h06

// ===================================================================
// header fields
`define PDXMB_HDR_EXT_BIT 15
`define PDXMB_HDR_NDO_LSB 12
`define PDXMB_SOP_PLAIN 2'h0
`define PDXMB_BLOCK_BYTES 9'h017
`define PDXMB_REPLY_LEN 5'h1b
`define PDXMB_ALERT_LEN 5'h06
`define PDXMB_ALERT_BATT_BIT 8'h02
`define PDXMB_LOAD_STEP_DEF 2'h0

// ===================================================================
// capability block offsets
`define PDXMB_OFS_VID 5'h00
`define PDXMB_OFS_PID 5'h02
`define PDXMB_OFS_CERT 5'h04
`define PDXMB_OFS_FW 5'h08
`define PDXMB_OFS_HW 5'h09
`define PDXMB_OFS_VREG 5'h0a
`define PDXMB_OFS_HOLD 5'h0b
`define PDXMB_OFS_COMPL 5'h0c

// ===================================================================
// register map and reset values
`define PDXMB_REG_CTRL 8'h00
`define PDXMB_REG_STATUS 8'h04
`define PDXMB_REG_CLEAR 8'h08
`define PDXMB_REG_ENABLE 8'h0c
`define PDXMB_REG_HSBAT 8'h10
`define PDXMB_REG_LASTRX 8'h14
`define PDXMB_CTRL_RST 3'h5
`define PDXMB_CTRL_SRC 0
`define PDXMB_CTRL_DRP 1
`define PDXMB_CTRL_ALERT 2
`define PDXMB_EV_REPLY 0
`define PDXMB_EV_ALERT 1
`define PDXMB_EV_UNDEF 2
`define PDXMB_EV_BADSOP 3
`define PDXMB_EV_REFUSE 4
`define PDXMB_EV_W 5

`endif

// ==== hdl/pdxmb_pkg.sv ====
// types shared by the extended message builder
package pdxmb_pkg;
   typedef enum logic [1:0] {IDLE, SEND} pdxmb_state_t;
   typedef enum logic {KIND_REPLY, KIND_ALERT} pdxmb_kind_t;
   typedef struct packed {
      logic [15:0] vid;
      logic [15:0] pid;
      logic [31:0] certId;
      logic [7:0] fwVer;
      logic [7:0] hwVer;
      logic [1:0] loadStep;
      logic [7:0] holdup;
      logic [2:0] compliance;
   } pdxmb_cfg_t;
endpackage

// ==== hdl/pdxmb_if.sv ====
// carriers between the builder and its type checker and block lookup
`timescale 1ns/1ns
`default_nettype none
interface pdxmb_chk_if;
   logic [4:0] msgType;
   logic [1:0] sopType;
   logic roleSrc;
   logic roleDrp;
   logic defined;
   logic sopOk;
   logic sendOk;
   modport user (output msgType, sopType, roleSrc, roleDrp, input defined, sopOk, sendOk);
   modport chk (input msgType, sopType, roleSrc, roleDrp, output defined, sopOk, sendOk);
endinterface

interface pdxmb_rom_if;
   logic [4:0] idx;
   logic [7:0] data;
   pdxmb_pkg::pdxmb_cfg_t cfg;
   modport user (output idx, cfg, input data);
   modport rom (input idx, cfg, output data);
endinterface
`default_nettype wire

// ==== hdl/pdxmb_type_check.sv ====
// extended type legality: defined code, start-of-packet and sender role
`timescale 1ns/1ns
`default_nettype none
`include "pdxmb_defs.svh"
module pdxmb_type_check (
   pdxmb_chk_if.chk c
);
   always_comb begin
      c.defined = (c.msgType != `PDXMB_XT_RSVD0) && (c.msgType < `PDXMB_XT_FIRST_RSVD);
      case (c.msgType)
         `PDXMB_XT_SRC_CAP_EXT, `PDXMB_XT_SRC_STATUS,
         `PDXMB_XT_GET_BAT_CAP, `PDXMB_XT_BAT_CAPS: c.sopOk = (c.sopType == `PDXMB_SOP_PLAIN);
         default: c.sopOk = c.defined;
      endcase
      // this end is never a cable plug, so sink-or-source types always pass
      case (c.msgType)
         `PDXMB_XT_SRC_CAP_EXT: c.sendOk = c.roleSrc || c.roleDrp;
         `PDXMB_XT_SRC_STATUS: c.sendOk = c.roleSrc;
         default: c.sendOk = c.defined;
      endcase
   end
endmodule // pdxmb_type_check
`default_nettype wire

// ==== hdl/pdxmb_source_capability_data_block_rom.sv ====
// capability data block byte lookup by offset
`timescale 1ns/1ns
`default_nettype none
`include "pdxmb_defs.svh"
module pdxmb_source_capability_data_block_rom (
   pdxmb_rom_if.rom r
);
   logic [1:0] step;
   always_comb begin
      // reserved load step codes fall back to the default
      step = r.cfg.loadStep[0] ? `PDXMB_LOAD_STEP_DEF : r.cfg.loadStep;
      case (r.idx)
         `PDXMB_OFS_VID: r.data = r.cfg.vid[7:0];
         `PDXMB_OFS_VID + 5'h01: r.data = r.cfg.vid[15:8];
         `PDXMB_OFS_PID: r.data = r.cfg.pid[7:0];
         `PDXMB_OFS_PID + 5'h01: r.data = r.cfg.pid[15:8];
         `PDXMB_OFS_CERT: r.data = r.cfg.certId[7:0];
         `PDXMB_OFS_CERT + 5'h01: r.data = r.cfg.certId[15:8];
         `PDXMB_OFS_CERT + 5'h02: r.data = r.cfg.certId[23:16];
         `PDXMB_OFS_CERT + 5'h03: r.data = r.cfg.certId[31:24];
         `PDXMB_OFS_FW: r.data = r.cfg.fwVer;
         `PDXMB_OFS_HW: r.data = r.cfg.hwVer;
         `PDXMB_OFS_VREG: r.data = {6'h00, step};
         `PDXMB_OFS_HOLD: r.data = r.cfg.holdup;
         `PDXMB_OFS_COMPL: r.data = {5'h00, r.cfg.compliance};
         // touch and peak current bytes are not built here
         default: r.data = 8'h00;
      endcase
   end
endmodule // pdxmb_source_capability_data_block_rom
`default_nettype wire

// ==== hdl/pdxmb_top.sv ====
// extended message builder: request handling, reply and alert framing, registers
//
// The register addresses and strobed register access were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "pdxmb_defs.svh"
module pdxmb_top (
   input wire logic clk_sys,
   input wire logic rst,
   // ===================================================================
   // register port
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [31:0] regRdData,
   output logic irq,
   // ===================================================================
   // received message headers from the protocol layer
   input wire logic rxValid,
   input wire logic rxExtended,
   input wire logic [4:0] rxType,
   input wire logic [1:0] rxSop,
   // ===================================================================
   // transmit byte stream
   output logic txValid,
   output logic [7:0] txByte,
   output logic txLast,
   output logic [1:0] txSop,
   input wire logic txReady,
   // ===================================================================
   // battery events and capability configuration
   input wire logic [3:0] hsBatChange,
   input wire logic [15:0] cfgVid,
   input wire logic [15:0] cfgPid,
   input wire logic [31:0] cfgCertId,
   input wire logic [7:0] cfgFwVer,
   input wire logic [7:0] cfgHwVer,
   input wire logic [1:0] cfgLoadStep,
   input wire logic [7:0] cfgHoldup,
   input wire logic [2:0] cfgCompliance
);
   pdxmb_chk_if rxChk();
   pdxmb_chk_if txChk();
   pdxmb_rom_if rom();

   pdxmb_pkg::pdxmb_state_t state_r;
   pdxmb_pkg::pdxmb_kind_t kind_r;
   pdxmb_pkg::pdxmb_cfg_t cfg_r;
   logic cfgLoaded_r;
   logic [2:0] ctrl_r;
   logic [`PDXMB_EV_W-1:0] stat_r;
   logic [`PDXMB_EV_W-1:0] stat_nxt;
   logic [`PDXMB_EV_W-1:0] en_r;
   logic [`PDXMB_EV_W-1:0] events;
   logic [6:0] lastRx_r;
   logic [3:0] hsPend_r;
   logic [3:0] hsSnap_r;
   logic reqPend_r;
   logic [4:0] pos_r;
   logic [4:0] len_r;
   logic doneReply_r;
   logic doneAlert_r;
   logic refuse_r;
   logic txValid_r;
   logic [7:0] txByte_r;
   logic txLast_r;
   logic [31:0] rdData_r;
   logic irq_r;
   logic isRequest;
   logic advance;
   logic [1:0] txSop_r;
   logic extRx;

   // ===================================================================
   // byte at a given stream position
   function automatic logic [7:0] streamByte(
      input pdxmb_pkg::pdxmb_kind_t kind,
      input logic [4:0] pos,
      input logic [3:0] hs,
      input logic [7:0] blockByte
   );
      logic [15:0] msgHdr;
      logic [15:0] extHdr;
      logic [31:0] alertObj;
      msgHdr = 16'h0000;
      extHdr = {7'h00, `PDXMB_BLOCK_BYTES};
      // battery change alert, hot-swap bits at 19:16
      alertObj = {`PDXMB_ALERT_BATT_BIT, 4'h0, hs, 16'h0000};
      if (kind == pdxmb_pkg::KIND_REPLY) begin
         msgHdr[`PDXMB_HDR_EXT_BIT] = 1'b1;
         msgHdr[4:0] = `PDXMB_XT_SRC_CAP_EXT;
      end else begin
         msgHdr[`PDXMB_HDR_NDO_LSB +: 3] = 3'h1;
         msgHdr[4:0] = `PDXMB_DT_SRC_ALERT;
      end
      case (pos)
         5'h00: streamByte = msgHdr[7:0];
         5'h01: streamByte = msgHdr[15:8];
         5'h02: streamByte = (kind == pdxmb_pkg::KIND_REPLY) ? extHdr[7:0] : alertObj[7:0];
         5'h03: streamByte = (kind == pdxmb_pkg::KIND_REPLY) ? extHdr[15:8] : alertObj[15:8];
         5'h04: streamByte = (kind == pdxmb_pkg::KIND_REPLY) ? blockByte : alertObj[23:16];
         5'h05: streamByte = (kind == pdxmb_pkg::KIND_REPLY) ? blockByte : alertObj[31:24];
         default: streamByte = blockByte;
      endcase
   endfunction

   // total bytes of each kind, headers included
   function automatic logic [4:0] msgLen(input pdxmb_pkg::pdxmb_kind_t kind);
      msgLen = (kind == pdxmb_pkg::KIND_REPLY) ? `PDXMB_REPLY_LEN : `PDXMB_ALERT_LEN;
   endfunction

   // ===================================================================
   // configuration capture, taken on the first clock after reset
   // later input changes are ignored until the next reset
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cfg_r <= '0;
         cfgLoaded_r <= 1'b0;
      end else if (!cfgLoaded_r) begin
         cfgLoaded_r <= 1'b1;
         cfg_r.vid <= cfgVid;
         cfg_r.pid <= cfgPid;
         cfg_r.certId <= cfgCertId;
         cfg_r.fwVer <= cfgFwVer;
         cfg_r.hwVer <= cfgHwVer;
         cfg_r.loadStep <= cfgLoadStep;
         cfg_r.holdup <= cfgHoldup;
         cfg_r.compliance <= cfgCompliance;
      end
   end

   // ===================================================================
   // checkers and block lookup
   assign rxChk.msgType = rxType;
   assign rxChk.sopType = rxSop;
   assign rxChk.roleSrc = ctrl_r[`PDXMB_CTRL_SRC];
   assign rxChk.roleDrp = ctrl_r[`PDXMB_CTRL_DRP];
   assign txChk.msgType = `PDXMB_XT_SRC_CAP_EXT;
   assign txChk.sopType = `PDXMB_SOP_PLAIN;
   assign txChk.roleSrc = ctrl_r[`PDXMB_CTRL_SRC];
   assign txChk.roleDrp = ctrl_r[`PDXMB_CTRL_DRP];
   // offset into the block is the stream position less the two headers
   assign rom.idx = pos_r - 5'h04;
   assign rom.cfg = cfg_r;

   pdxmb_type_check rxCheck (
      .c(rxChk.chk)
   );
   // fixed to the reply type, so it only gates on role
   pdxmb_type_check txCheck (
      .c(txChk.chk)
   );
   pdxmb_source_capability_data_block_rom blockRom (
      .r(rom.rom)
   );

   // ===================================================================
   // request detection
   assign extRx = rxValid && rxExtended;
   assign isRequest = rxValid && !rxExtended &&
      (rxType == `PDXMB_CT_GET_SRC_CAP_EXT) && (rxSop == `PDXMB_SOP_PLAIN);

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         reqPend_r <= 1'b0;
         refuse_r <= 1'b0;
      end else begin
         // a refused request is dropped, only flagged
         refuse_r <= isRequest && !(txChk.sendOk && txChk.sopOk);
         // a new request in the cycle the reply starts stays pending
         if (isRequest && txChk.sendOk && txChk.sopOk) begin
            reqPend_r <= 1'b1;
         end else if (state_r == pdxmb_pkg::IDLE) begin
            reqPend_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         lastRx_r <= 7'h00;
      end else if (extRx) begin
         // kept for software to see what came last
         lastRx_r <= {rxSop, rxType};
      end
   end

   // ===================================================================
   // hot-swap battery change bits
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hsPend_r <= 4'h0;
      end else if (doneAlert_r) begin
         // only bits that were sent clear; fresh changes survive
         hsPend_r <= (hsPend_r & ~hsSnap_r) | hsBatChange;
      end else begin
         // sticky until an alert carries them
         hsPend_r <= hsPend_r | hsBatChange;
      end
   end

   // ===================================================================
   // framing state machine
   // a shown byte stays until taken
   assign advance = !txValid_r || txReady;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_r <= pdxmb_pkg::IDLE;
         kind_r <= pdxmb_pkg::KIND_REPLY;
         pos_r <= 5'h00;
         len_r <= 5'h00;
         hsSnap_r <= 4'h0;
         txValid_r <= 1'b0;
         txByte_r <= 8'h00;
         txLast_r <= 1'b0;
         doneReply_r <= 1'b0;
         doneAlert_r <= 1'b0;
      end else begin
         doneReply_r <= 1'b0;
         doneAlert_r <= 1'b0;
         case (state_r)
            pdxmb_pkg::IDLE: begin
               pos_r <= 5'h00;
               // a pending reply goes before an alert
               // no alert in the cycle the sent bits clear, else they go twice
               if (reqPend_r) begin
                  kind_r <= pdxmb_pkg::KIND_REPLY;
                  len_r <= msgLen(pdxmb_pkg::KIND_REPLY);
                  state_r <= pdxmb_pkg::SEND;
               end else if (ctrl_r[`PDXMB_CTRL_ALERT] && (hsPend_r != 4'h0) && cfgLoaded_r && !doneAlert_r) begin
                  kind_r <= pdxmb_pkg::KIND_ALERT;
                  len_r <= msgLen(pdxmb_pkg::KIND_ALERT);
                  // changes during the alert wait for the next one
                  hsSnap_r <= hsPend_r;
                  state_r <= pdxmb_pkg::SEND;
               end
            end
            pdxmb_pkg::SEND: begin
               if (advance) begin
                  if (pos_r == len_r) begin
                     // last byte taken: drop valid and report
                     txValid_r <= 1'b0;
                     txLast_r <= 1'b0;
                     state_r <= pdxmb_pkg::IDLE;
                     doneReply_r <= (kind_r == pdxmb_pkg::KIND_REPLY);
                     doneAlert_r <= (kind_r == pdxmb_pkg::KIND_ALERT);
                  end else begin
                     txValid_r <= 1'b1;
                     txByte_r <= streamByte(kind_r, pos_r, hsSnap_r, rom.data);
                     txLast_r <= (pos_r == len_r - 5'h01);
                     pos_r <= pos_r + 5'h01;
                  end
               end
            end
            default: state_r <= pdxmb_pkg::IDLE;
         endcase
      end
   end

   // ===================================================================
   // events and interrupt
   always_comb begin
      events = '0;
      events[`PDXMB_EV_REPLY] = doneReply_r;
      events[`PDXMB_EV_ALERT] = doneAlert_r;
      events[`PDXMB_EV_UNDEF] = extRx && !rxChk.defined;
      events[`PDXMB_EV_BADSOP] = extRx && rxChk.defined && !rxChk.sopOk;
      events[`PDXMB_EV_REFUSE] = refuse_r;
      stat_nxt = stat_r;
      // a clear write acts in its own cycle
      if (regWrStb && (regAddr == `PDXMB_REG_CLEAR)) begin
         stat_nxt = stat_nxt & ~regWrData[`PDXMB_EV_W-1:0];
      end
      // set wins over a clear in the same cycle
      stat_nxt = stat_nxt | events;
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stat_r <= '0;
         irq_r <= 1'b0;
      end else begin
         stat_r <= stat_nxt;
         // from the next status, so irq rises with its bit
         irq_r <= |(stat_nxt & en_r);
      end
   end

   // ===================================================================
   // register writes and reads
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_r <= `PDXMB_CTRL_RST;
         en_r <= '0;
      end else if (regWrStb) begin
         case (regAddr)
            `PDXMB_REG_CTRL: ctrl_r <= regWrData[2:0];
            `PDXMB_REG_ENABLE: en_r <= regWrData[`PDXMB_EV_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdData_r <= 32'h00000000;
      end else if (regRdStb) begin
         case (regAddr)
            `PDXMB_REG_CTRL: rdData_r <= {29'h00000000, ctrl_r};
            `PDXMB_REG_STATUS: rdData_r <= {27'h0000000, stat_r};
            `PDXMB_REG_ENABLE: rdData_r <= {27'h0000000, en_r};
            `PDXMB_REG_HSBAT: rdData_r <= {12'h000, hsPend_r, 16'h0000};
            `PDXMB_REG_LASTRX: rdData_r <= {25'h0000000, lastRx_r};
            // unmapped and write-only addresses read as zero
            default: rdData_r <= 32'h00000000;
         endcase
      end else begin
         rdData_r <= 32'h00000000;
      end
   end

   // ===================================================================
   // packet type, plain for both messages
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         txSop_r <= 2'h0;
      end else begin
         txSop_r <= `PDXMB_SOP_PLAIN;
      end
   end

   // ===================================================================
   // outputs
   assign regRdData = rdData_r;
   assign irq = irq_r;
   assign txValid = txValid_r;
   assign txByte = txByte_r;
   assign txLast = txLast_r;
   assign txSop = txSop_r;
endmodule // pdxmb_top
`default_nettype wire

// ==== testbench/pdxmb_props.sv ====
// concurrent checks on the ports of the extended message builder
`timescale 1ns/1ns
`default_nettype none
module pdxmb_props (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrStb,
   input wire logic rxValid,
   input wire logic rxExtended,
   input wire logic [4:0] rxType,
   input wire logic [1:0] rxSop,
   input wire logic txValid,
   input wire logic [7:0] txByte,
   input wire logic txLast,
   input wire logic [1:0] txSop,
   input wire logic txReady
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic [4:0] idx_r;
   logic rep_r;
   logic [2:0] ctrl_r;
   // first byte 0x01 marks a reply, 0x06 an alert
   wire rep = (idx_r == 5'h00) ? (txByte == 8'h01) : rep_r;
   wire req = rxValid && !rxExtended && rxType == 5'h11 && rxSop == 2'h0;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         idx_r <= 5'h00;
         rep_r <= 1'b0;
      end else if (txValid && txReady) begin
         idx_r <= txLast ? 5'h00 : idx_r + 5'h01;
         rep_r <= rep;
      end
   end
   // shadow of the role bits, so refusals can be told apart
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst)
         ctrl_r <= 3'h5;
      else if (regWrStb && regAddr == 8'h00)
         ctrl_r <= regWrData[2:0];
   end
   // ===================================================================
   // checks
   AST_TX_SOP: assert property (txSop == 2'h0) else $error("reply not on plain packet type");
   AST_HOLD: assert property (txValid && !txReady |=> txValid && $stable(txByte) && $stable(txLast))
      else $error("byte changed before acceptance");
   AST_REPLY: assert property (req && ctrl_r[1:0] != 2'h0 |-> ##[3:400] ($rose(txValid) && txByte == 8'h01))
      else $error("capability request not answered");
   AST_REFUSE: assert property (!txValid [*4] ##0 (req && ctrl_r == 3'h0) |=> !txValid [*8])
      else $error("reply sent without source role");
   AST_LEN: assert property (txValid && txReady && txLast |-> idx_r == (rep ? 5'h1a : 5'h05))
      else $error("message length wrong");
   AST_EXT_FLAG: assert property (txValid && rep && idx_r == 5'h01 |-> txByte[7])
      else $error("extended flag missing");
   AST_DATA_SIZE: assert property (txValid && rep && idx_r == 5'h02 |-> txByte == 8'h17)
      else $error("data size not 23");
   AST_VREG: assert property (txValid && rep && idx_r == 5'h0e |-> txByte[7:2] == 6'h00 && !txByte[0])
      else $error("voltage regulation byte bad");
   AST_COMPL: assert property (txValid && rep && idx_r == 5'h10 |-> txByte[7:3] == 5'h00)
      else $error("compliance byte bad");
   AST_ALERT: assert property (txValid && txReady && !rep && idx_r == 5'h04 |-> txByte[7:4] == 4'h0 ##1 txByte == 8'h02)
      else $error("alert object bad");
   cover property (req ##[3:400] $rose(txValid));
   cover property (txValid && txReady && txLast && !rep);
   cover property (req && ctrl_r[1:0] == 2'h0);
endmodule // pdxmb_props
bind pdxmb_top pdxmb_props i_pdxmb_props (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
   .regWrData(regWrData), .regWrStb(regWrStb), .rxValid(rxValid), .rxExtended(rxExtended),
   .rxType(rxType), .rxSop(rxSop), .txValid(txValid), .txByte(txByte), .txLast(txLast),
   .txSop(txSop), .txReady(txReady));
`default_nettype wire

// ==== testbench/pdxmb_partner.sv ====
// port partner model: sends message headers and takes the byte stream
`timescale 1ns/1ns
`default_nettype none
module pdxmb_partner (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic slow,
   output logic rxValid,
   output logic rxExtended,
   output logic [4:0] rxType,
   output logic [1:0] rxSop,
   input wire logic txValid,
   input wire logic [7:0] txByte,
   input wire logic txLast,
   output logic txReady
);
   logic [7:0] got[$];
   int msgs = 0;
   initial begin
      rxValid = 1'b0;
      rxExtended = 1'b0;
      rxType = 5'h00;
      rxSop = 2'h0;
      txReady = 1'b0;
   end
   // slow mode stalls at random to exercise the hold of each byte
   always @(posedge clk_sys) begin
      txReady <= rst ? 1'b0 : (!slow || $urandom_range(1));
      if (!rst && txValid && txReady) begin
         got.push_back(txByte);
         if (txLast)
            msgs <= msgs + 1;
      end
   end
   task automatic sendHdr(input logic ext, input logic [4:0] t, input logic [1:0] s);
      @(posedge clk_sys);
      rxValid <= 1'b1;
      rxExtended <= ext;
      rxType <= t;
      rxSop <= s;
      @(posedge clk_sys);
      rxValid <= 1'b0;
      rxType <= ~t;
      rxSop <= ~s;
   endtask
endmodule // pdxmb_partner
`default_nettype wire

// ==== testbench/pd_extended_message_builder_tb.sv ====
// self-checking bench of the extended message builder
`timescale 1ns/1ns
`default_nettype none
module pd_extended_message_builder_tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWrData = 32'h0;
   logic regWrStb = 1'b0;
   logic regRdStb = 1'b0;
   logic slow = 1'b0;
   logic [3:0] hs = 4'h0;
   logic [31:0] regRdData, rd;
   logic irq, rxValid, rxExtended, txValid, txLast, txReady;
   logic [4:0] rxType;
   logic [1:0] rxSop, txSop;
   logic [7:0] txByte;
   logic [127:0] rnd;
   logic [3:0] h;
   logic [1:0] s;
   pdxmb_pkg::pdxmb_cfg_t cfg;
   int miscompares = 0;
   int samples_checked = 0;
   int cyc = 0;
   logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'hfc};
   always #5 clk_sys = ~clk_sys;
   pdxmb_top i_pdxmb_top (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .irq(irq), .rxValid(rxValid),
      .rxExtended(rxExtended), .rxType(rxType), .rxSop(rxSop), .txValid(txValid), .txByte(txByte),
      .txLast(txLast), .txSop(txSop), .txReady(txReady), .hsBatChange(hs), .cfgVid(cfg.vid),
      .cfgPid(cfg.pid), .cfgCertId(cfg.certId), .cfgFwVer(cfg.fwVer), .cfgHwVer(cfg.hwVer),
      .cfgLoadStep(cfg.loadStep), .cfgHoldup(cfg.holdup), .cfgCompliance(cfg.compliance));
   pdxmb_partner i_pdxmb_partner (.clk_sys(clk_sys), .rst(rst), .slow(slow), .rxValid(rxValid),
      .rxExtended(rxExtended), .rxType(rxType), .rxSop(rxSop), .txValid(txValid), .txByte(txByte),
      .txLast(txLast), .txReady(txReady));
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 60000) begin
         miscompares++;
         give_verdict();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWrStb <= 1'b1;
      @(posedge clk_sys);
      regWrStb <= 1'b0;
   endtask
   task automatic rdReg(input logic [7:0] a);
      @(posedge clk_sys);
      regAddr <= a;
      regRdStb <= 1'b1;
      @(posedge clk_sys);
      regRdStb <= 1'b0;
      #1 rd = regRdData;
   endtask
   task automatic waitMsgs(input int n);
      for (int i = 0; i < 3000 && i_pdxmb_partner.msgs < n; i++)
         @(posedge clk_sys);
      check("message count", i_pdxmb_partner.msgs, n);
   endtask
   // byte 0 sits in the low bits, so multi-byte fields come out low byte first
   function automatic logic [7:0] expByte(input logic isRep, input int i, input logic [3:0] hb);
      logic [215:0] b;
      b = {80'h0, 5'h0, cfg.compliance, cfg.holdup, 6'h0, (cfg.loadStep[0] ? 2'h0 : cfg.loadStep),
         cfg.hwVer, cfg.fwVer, cfg.certId, cfg.pid, cfg.vid, 16'h0017, 16'h8001};
      if (!isRep)
         b = {168'h0, 8'h02, 4'h0, hb, 16'h0000, 16'h1006};
      return b[i*8 +: 8];
   endfunction
   task automatic cmpMsg(input logic isRep, input logic [3:0] hb);
      for (int i = 0; i < (isRep ? 27 : 6); i++)
         check("message byte", i_pdxmb_partner.got.pop_front(), expByte(isRep, i, hb));
   endtask
   // ===================================================================
   // main sequence
   initial begin
      void'($urandom(32'he9ce));
      rnd = {$urandom, $urandom, $urandom, $urandom};
      cfg = rnd[92:0];
      cfg.loadStep = 2'h3;
      repeat (2) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      wr(8'h04, 32'h1f);
      for (int k = 0; k < 6; k++) begin
         rdReg(ra[k]);
         check("reset value", rd, (k == 0) ? 32'h5 : 32'h0);
      end
      wr(8'h0c, 32'h1f);
      i_pdxmb_partner.sendHdr(1'b0, 5'h11, 2'h0);
      waitMsgs(1);
      cmpMsg(1'b1, 4'h0);
      rdReg(8'h04);
      check("reply sent", rd[0], 1'b1);
      check("interrupt", irq, 1'b1);
      wr(8'h08, 32'h1f);
      repeat (2) @(posedge clk_sys);
      check("interrupt cleared", irq, 1'b0);
      slow <= 1'b1;
      i_pdxmb_partner.sendHdr(1'b0, 5'h11, 2'h0);
      repeat (10) @(posedge clk_sys);
      i_pdxmb_partner.sendHdr(1'b0, 5'h11, 2'h0);
      waitMsgs(3);
      cmpMsg(1'b1, 4'h0);
      cmpMsg(1'b1, 4'h0);
      wr(8'h00, 32'h0);
      i_pdxmb_partner.sendHdr(1'b0, 5'h11, 2'h0);
      repeat (40) @(posedge clk_sys);
      check("refused count", i_pdxmb_partner.msgs, 3);
      rdReg(8'h04);
      check("refused flag", rd[4], 1'b1);
      wr(8'h00, 32'h2);
      i_pdxmb_partner.sendHdr(1'b0, 5'h11, 2'h0);
      waitMsgs(4);
      cmpMsg(1'b1, 4'h0);
      for (int t = 0; t < 32; t++) begin
         s = 2'($urandom_range(3));
         wr(8'h08, 32'h1f);
         i_pdxmb_partner.sendHdr(1'b1, 5'(t), s);
         rdReg(8'h04);
         check("undefined type", rd[2], t == 0 || t > 9);
         if (t != 0 && t < 10)
            check("sop misuse", rd[3], s != 2'h0 && (t inside {1, 2, 3, 5}));
         rdReg(8'h14);
         check("type decode", rd[6:0], {s, 5'(t)});
      end
      wr(8'h00, 32'h1);
      h = 4'($urandom_range(15, 1));
      @(posedge clk_sys);
      hs <= h;
      @(posedge clk_sys);
      hs <= 4'h0;
      rdReg(8'h10);
      check("battery bits", rd, {12'h0, h, 16'h0});
      wr(8'h00, 32'h5);
      waitMsgs(5);
      cmpMsg(1'b0, h);
      rdReg(8'h10);
      check("battery bits cleared", rd, 32'h0);
      h = ~h | 4'h1;
      wr(8'h08, 32'h1f);
      fork
         begin
            @(posedge clk_sys);
            hs <= h;
            @(posedge clk_sys);
            hs <= 4'h0;
         end
         i_pdxmb_partner.sendHdr(1'b0, 5'h11, 2'h0);
      join
      waitMsgs(7);
      cmpMsg(1'b1, 4'h0);
      cmpMsg(1'b0, h);
      rdReg(8'h04);
      check("alert sent", rd[1], 1'b1);
      give_verdict();
   end
endmodule // pd_extended_message_builder_tb
`default_nettype wire
